/* sgram_gfx_pkg.sv */
// Purpose: shared constants and types for the graphics write functions
// Assumes: 32-bit data port, two banks, 8-column blocks
// Notes:   bit offsets, widths and the mask, color and plane reset values live here
`default_nettype none
package sgram_gfx_pkg;
   localparam int DATA_W      = 32;
   localparam int MASK_W      = 4;
   localparam int BANKS       = 2;
   localparam int COL_W       = 8;
   localparam int ROW_W       = 9;
   localparam int BLOCK_COLS  = 8;
   localparam int BLOCK_LSB   = 3;
   localparam int ADDR_W      = 11;
   localparam int A_MASK_BIT  = 5;
   localparam int A_COLOR_BIT = 6;
   localparam int A_BANK_BIT  = 10;
   localparam int A_APRE_BIT  = 9;
   localparam logic [31:0] MASK_RESET  = 32'hffff_ffff;
   localparam logic [31:0] COLOR_RESET = 32'h0000_0000;
   localparam logic [1:0]  PLANE_RESET = 2'h0;

   // decoded command of one cycle
   typedef enum logic [2:0] {
      CMD_NOP   = 3'h0,
      CMD_ACT   = 3'h1,
      CMD_WRITE = 3'h3,
      CMD_SPEC  = 3'h2,
      CMD_OTHER = 3'h6
   } cmd_t;

   // write request handed to the array
   typedef struct packed {
      logic              bank;
      logic [ROW_W-1:0]  row;
      logic [COL_W-1:0]  col;
      logic              block;
      logic [31:0]       data;
      logic [31:0]       bitEn;
      logic [7:0]        colEn0;
      logic [7:0]        colEn1;
      logic [7:0]        colEn2;
      logic [7:0]        colEn3;
   } wr_req_t;
endpackage : sgram_gfx_pkg
`default_nettype wire

/* wr_req_if.sv */
// Purpose: carries write requests from the decoder to the two-entry buffer
// Assumes: single clock
// Notes:   valid/ready handshake
`timescale 1ns/1ps
`default_nettype none
interface wr_req_if;
   logic                    valid;
   logic                    ready;
   sgram_gfx_pkg::wr_req_t  req;
   modport src  (output valid, output req, input ready);
   modport sink (input valid, input req, output ready);
endinterface : wr_req_if
`default_nettype wire

/* skid_buffer.sv */
// Purpose: two-entry buffer in the write path
// Assumes: one clock, async active-high reset
// Notes:   full at two entries; ready drops so no word is lost
`timescale 1ns/1ps
`default_nettype none
module skid_buffer (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   wr_req_if.sink                 inPort,
   output logic                   outValid,
   input  wire logic              outReady,
   output sgram_gfx_pkg::wr_req_t outReq
);
   typedef struct packed {
      sgram_gfx_pkg::wr_req_t e0;
      sgram_gfx_pkg::wr_req_t e1;
      logic [1:0]             count;
   } buf_state_t;

   buf_state_t st;
   buf_state_t next_st;
   logic       push;
   logic       pop;

   assign inPort.ready = (st.count != 2'h2);
   assign outValid     = (st.count != 2'h0);
   assign outReq       = st.e0;
   assign push         = inPort.valid && inPort.ready;
   assign pop          = outValid && outReady;

   always_comb
   begin
      next_st = st;
      if (pop)
      begin
         next_st.e0 = st.e1;
      end
      if (push)
      begin
         if (st.count == 2'h0 || (st.count == 2'h1 && pop))
         begin
            next_st.e0 = inPort.req;
         end
         else
         begin
            next_st.e1 = inPort.req;
         end
      end
      next_st.count = st.count + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end
endmodule : skid_buffer
`default_nettype wire

/* sgram_gfx_write.sv */
// Purpose: graphics write front end: mask/color load, bit-plane mask, block write
// Assumes: controller keeps command spacing and data-bus rules
// Notes:   array writes leave through a buffered valid/ready port
`timescale 1ns/1ps
`default_nettype none

// How it works
// - special set with address 5 loads mask
// - special set with address 6 loads color
// - new command accepted right after loads
// - activate sets bank masking from select
// - mask bit one writes, zero keeps
// - write with select high is block
// - block covers eight aligned columns
// - block data from color register
// - data pin 8b+c selects column c
// - color masked by pins, planes, bytes
// - block write is single non-burst
// - one mask, one color, shared
// - four byte masks, eight pins each
module sgram_gfx_write (
   input  wire logic                             ref_clk,
   input  wire logic                             rst,
   input  wire logic                             chipSelect_n,
   input  wire logic                             rowStrobe_n,
   input  wire logic                             colStrobe_n,
   input  wire logic                             writeEnable_n,
   input  wire logic                             special_function_select,
   input  wire logic [sgram_gfx_pkg::ADDR_W-1:0] addr,
   input  wire logic [sgram_gfx_pkg::MASK_W-1:0] byteMask,
   input  wire logic [sgram_gfx_pkg::DATA_W-1:0] dqIn,
   output logic                                  arrayValid,
   input  wire logic                             arrayReady,
   output sgram_gfx_pkg::wr_req_t                arrayReq,
   output logic [sgram_gfx_pkg::DATA_W-1:0]      maskValue,
   output logic [sgram_gfx_pkg::DATA_W-1:0]      colorValue,
   output logic [sgram_gfx_pkg::BANKS-1:0]       bitplaneEnabled,
   output logic                                  cmdStall
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [31:0]                 mask;
      logic [31:0]                 color;
      logic [1:0]                  planeOn;
      logic [sgram_gfx_pkg::ROW_W-1:0] row0;
      logic [sgram_gfx_pkg::ROW_W-1:0] row1;
   } gfx_state_t;

   gfx_state_t st;
   gfx_state_t next_st;
   sgram_gfx_pkg::cmd_t cmd;
   wr_req_if            reqBus ();
   sgram_gfx_pkg::wr_req_t req;
   logic                bank;
   logic                planeMaskOn;
   logic [31:0]         byteBits;
   logic [31:0]         planeBits;
   logic                isBlock;

   // ****************************************
   // command decode
   // ****************************************
   always_comb
   begin
      cmd = sgram_gfx_pkg::CMD_NOP;
      if (!chipSelect_n)
      begin
         unique case ({rowStrobe_n, colStrobe_n, writeEnable_n})
            3'b000:  cmd = sgram_gfx_pkg::CMD_SPEC;
            3'b011:  cmd = sgram_gfx_pkg::CMD_ACT;
            3'b100:  cmd = sgram_gfx_pkg::CMD_WRITE;
            3'b111:  cmd = sgram_gfx_pkg::CMD_NOP;
            default: cmd = sgram_gfx_pkg::CMD_OTHER;
         endcase
      end
   end

   assign bank    = addr[sgram_gfx_pkg::A_BANK_BIT];
   assign planeMaskOn = st.planeOn[bank];
   assign isBlock = special_function_select;

   // byte mask spans eight pins, high level blocks the byte
   genvar gb;
   generate
      for (gb = 0; gb < sgram_gfx_pkg::MASK_W; gb++)
      begin : g_byte
         assign byteBits[8*gb +: 8] = {8{~byteMask[gb]}};
      end
   endgenerate

   // with masking off every plane is written
   assign planeBits = planeMaskOn ? st.mask : 32'hffff_ffff;

   // ****************************************
   // write request build
   // ****************************************
   always_comb
   begin
      req        = '0;
      req.bank   = bank;
      req.row    = bank ? st.row1 : st.row0;
      req.block  = isBlock;
      req.bitEn  = planeBits & byteBits;
      if (isBlock)
      begin
         // low three column bits dropped to align the block
         req.col    = {addr[sgram_gfx_pkg::COL_W-1:sgram_gfx_pkg::BLOCK_LSB],
                       3'h0};
         req.data   = st.color;
         req.colEn0 = dqIn[7:0];
         req.colEn1 = dqIn[15:8];
         req.colEn2 = dqIn[23:16];
         req.colEn3 = dqIn[31:24];
      end
      else
      begin
         req.col    = addr[sgram_gfx_pkg::COL_W-1:0];
         req.data   = dqIn;
         req.colEn0 = 8'h01;
         req.colEn1 = 8'h01;
         req.colEn2 = 8'h01;
         req.colEn3 = 8'h01;
      end
   end

   // one request per command; block never bursts
   assign reqBus.valid = (cmd == sgram_gfx_pkg::CMD_WRITE);
   assign reqBus.req   = req;
   assign cmdStall     = ~reqBus.ready;

   // ****************************************
   // register updates
   // ****************************************
   always_comb
   begin
      next_st = st;
      if (cmd == sgram_gfx_pkg::CMD_SPEC && special_function_select)
      begin
         // both bits high loads both from the same cycle's data
         if (addr[sgram_gfx_pkg::A_MASK_BIT])
         begin
            next_st.mask = dqIn;
         end
         if (addr[sgram_gfx_pkg::A_COLOR_BIT])
         begin
            next_st.color = dqIn;
         end
      end
      if (cmd == sgram_gfx_pkg::CMD_ACT)
      begin
         next_st.planeOn[bank] = special_function_select;
         if (bank)
         begin
            next_st.row1 = addr[sgram_gfx_pkg::ROW_W-1:0];
         end
         else
         begin
            next_st.row0 = addr[sgram_gfx_pkg::ROW_W-1:0];
         end
      end
   end

   // loads complete in one edge, so the next cycle takes a command
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st.mask  <= sgram_gfx_pkg::MASK_RESET;
         st.color <= sgram_gfx_pkg::COLOR_RESET;
         st.planeOn <= sgram_gfx_pkg::PLANE_RESET;
         st.row0  <= '0;
         st.row1  <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign maskValue       = st.mask;
   assign colorValue      = st.color;
   assign bitplaneEnabled = st.planeOn;

   // ****************************************
   // buffered path to the array
   // ****************************************
   skid_buffer u_buf (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .inPort   (reqBus.sink),
      .outValid (arrayValid),
      .outReady (arrayReady),
      .outReq   (arrayReq)
   );
endmodule : sgram_gfx_write
`default_nettype wire

/* sgram_gfx_monitor.sv */
// Purpose: port checker for the graphics write block
// Assumes: one clock, async reset
// Notes: request field checks only when buffer was empty
`timescale 1ns/1ps
`default_nettype none
module sgram_gfx_monitor (
   input wire logic                   ref_clk,
   input wire logic                   rst,
   input wire logic                   chipSelect_n,
   input wire logic                   rowStrobe_n,
   input wire logic                   colStrobe_n,
   input wire logic                   writeEnable_n,
   input wire logic                   special_function_select,
   input wire logic [10:0]            addr,
   input wire logic [3:0]             byteMask,
   input wire logic [31:0]            dqIn,
   input wire logic                   arrayValid,
   input wire logic                   arrayReady,
   input wire sgram_gfx_pkg::wr_req_t arrayReq,
   input wire logic [31:0]            maskValue,
   input wire logic [31:0]            colorValue,
   input wire logic [1:0]             bitplaneEnabled,
   input wire logic                   cmdStall
);
   // ********
   // checks
   // ********
   wire logic [3:0]  pins = {chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n};
   wire logic        planeNow = bitplaneEnabled[addr[10]];
   wire logic [31:0] keep = {{8{byteMask[3]}}, {8{byteMask[2]}},
                             {8{byteMask[1]}}, {8{byteMask[0]}}};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_spec;
      pins == 4'h0 && special_function_select;
   endsequence
   // a non-empty buffer would hide the new word behind the old head
   sequence s_wr_empty;
      pins == 4'h4 && !cmdStall && !arrayValid;
   endsequence
   a_mask_load: assert property (s_spec ##0 addr[5] |=> maskValue == $past(dqIn))
      else $error("mask not loaded");
   a_color_load: assert property (s_spec ##0 addr[6] |=> colorValue == $past(dqIn))
      else $error("color not loaded");
   a_mask_keep: assert property (
      !(pins == 4'h0 && special_function_select && addr[5]) |=> $stable(maskValue))
      else $error("mask changed");
   a_act_plane: assert property (
      pins == 4'h3 |=> bitplaneEnabled[$past(addr[10])] == $past(special_function_select))
      else $error("plane enable wrong");
   a_write_push: assert property (pins == 4'h4 && !cmdStall |=> arrayValid)
      else $error("write lost");
   a_block_data: assert property (
      s_wr_empty ##0 special_function_select |=> arrayReq.block
      && arrayReq.data == $past(colorValue) && {arrayReq.colEn3, arrayReq.colEn2,
      arrayReq.colEn1, arrayReq.colEn0} == $past(dqIn))
      else $error("block data wrong");
   a_block_align: assert property (
      s_wr_empty ##0 special_function_select |=> arrayReq.col[7:3] == $past(addr[7:3]))
      else $error("block column wrong");
   a_normal_kind: assert property (
      s_wr_empty ##0 !special_function_select
      |=> !arrayReq.block && arrayReq.data == $past(dqIn))
      else $error("normal write wrong");
   a_bit_enable: assert property (
      s_wr_empty |=> arrayReq.bitEn ==
      (($past(planeNow) ? $past(maskValue) : 32'hffff_ffff) & ~$past(keep)))
      else $error("bit enables wrong");
   a_hold_req: assert property (arrayValid && !arrayReady |=> arrayValid && $stable(arrayReq))
      else $error("stalled word lost");
endmodule : sgram_gfx_monitor
bind sgram_gfx_write sgram_gfx_monitor u_mon (.ref_clk, .rst, .chipSelect_n, .rowStrobe_n,
   .colStrobe_n, .writeEnable_n, .special_function_select, .addr, .byteMask, .dqIn,
   .arrayValid, .arrayReady, .arrayReq, .maskValue, .colorValue, .bitplaneEnabled,
   .cmdStall);
`default_nettype wire

/* array_sink.sv */
// Purpose: array side partner, pops words
// Assumes: one clock
// Notes: stall holds ready low
`timescale 1ns/1ps
`default_nettype none
module array_sink (
   input wire logic  ref_clk,
   input wire logic  rst,
   input wire logic  stall,
   input wire logic  arrayValid,
   output logic      arrayReady,
   output logic [7:0] popCount
);
   assign arrayReady = !stall;
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
         popCount <= 8'h00;
      else if (arrayValid && arrayReady)
         popCount <= popCount + 8'h01;
endmodule : array_sink
`default_nettype wire

/* tb_top.sv */
// Purpose: scenario bench for graphics writes
// Assumes: bench is the controller
// Notes: pins are {cs,ras,cas,we}
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        ref_clk, rst, stall, funcSel, arrayValid, arrayReady, cmdStall;
   logic [3:0]  pins, byteMask;
   logic [10:0] addr;
   logic [31:0] dqIn, maskValue, colorValue;
   logic [1:0]  planes;
   logic [7:0]  popCount;
   int          n_mismatch, samples_checked;
   sgram_gfx_pkg::wr_req_t arrayReq;
   sgram_gfx_write u_dut (.ref_clk, .rst, .chipSelect_n(pins[3]), .rowStrobe_n(pins[2]),
      .colStrobe_n(pins[1]), .writeEnable_n(pins[0]), .special_function_select(funcSel),
      .addr, .byteMask, .dqIn, .arrayValid, .arrayReady, .arrayReq, .maskValue,
      .colorValue, .bitplaneEnabled(planes), .cmdStall);
   array_sink u_sink (.ref_clk, .rst, .stall, .arrayValid, .arrayReady, .popCount);
   initial
   begin
      ref_clk = 0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic issue(input logic [3:0] p, input logic s, input logic [10:0] a,
      input logic [3:0] m, input logic [31:0] d);
      // bench never reads, auto-precharges or mode-sets
      @(posedge ref_clk);
      pins <= p;
      funcSel <= s;
      addr <= a;
      byteMask <= m;
      dqIn <= d;
   endtask : issue
   task automatic idle;
      @(posedge ref_clk);
      pins <= 4'hf;
      #1;
   endtask : idle
   task automatic wrap_up;
      $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   task automatic t_loads;
      chk(maskValue, 32'hffff_ffff);
      chk(32'(planes), 32'h0000_0000);
      issue(4'h0, 1, 11'h060, 4'h0, 32'h1234_5678);
      idle();
      chk(maskValue, 32'h1234_5678);
      chk(colorValue, 32'h1234_5678);
      issue(4'h0, 1, 11'h020, 4'h0, 32'h7ebf_7d76);
      issue(4'h0, 1, 11'h040, 4'h0, 32'hc3e1_0fa3);
      issue(4'h3, 1, 11'h4a5, 4'h0, 32'h0000_0000);
      issue(4'h3, 0, 11'h033, 4'h0, 32'h0000_0000);
      idle();
      chk(maskValue, 32'h7ebf_7d76);
      chk(colorValue, 32'hc3e1_0fa3);
      chk(32'(planes), 32'h0000_0002);
   endtask : t_loads
   task automatic t_writes;
      issue(4'h4, 0, 11'h405, 4'h1, 32'hffff_0000);
      idle();
      chk(arrayReq.data, 32'hffff_0000);
      chk(arrayReq.bitEn, 32'h7ebf_7d00);
      chk(32'(arrayReq.bank), 32'h0000_0001);
      chk(32'(arrayReq.row), 32'h0000_00a5);
      chk(32'(arrayReq.col), 32'h0000_0005);
      issue(4'h4, 0, 11'h005, 4'h2, 32'h0000_00ff);
      idle();
      chk(arrayReq.bitEn, 32'hffff_00ff);
      chk(32'(arrayReq.row), 32'h0000_0033);
      issue(4'h4, 1, 11'h40d, 4'h1, 32'h7777_bbbb);
      idle();
      chk(32'(arrayReq.block), 32'h0000_0001);
      chk(arrayReq.data, 32'hc3e1_0fa3);
      chk({arrayReq.colEn3, arrayReq.colEn2, arrayReq.colEn1, arrayReq.colEn0},
         32'h7777_bbbb);
      chk(32'(arrayReq.col[7:3]), 32'h0000_0001);
      chk(arrayReq.bitEn, 32'h7ebf_7d00);
   endtask : t_writes
   task automatic t_stall;
      logic [7:0] start;
      int i;
      // the block word still queued drains at this edge, before the count is taken
      @(posedge ref_clk);
      stall <= 1;
      #1;
      start = popCount;
      issue(4'h4, 0, 11'h001, 4'h0, 32'h0000_0001);
      issue(4'h4, 0, 11'h002, 4'h0, 32'h0000_0002);
      idle();
      chk(32'(cmdStall), 32'h0000_0001);
      chk(arrayReq.data, 32'h0000_0001);
      @(posedge ref_clk);
      stall <= 0;
      #1;
      for (i = 0; i < 20 && arrayValid; i++)
      begin
         @(posedge ref_clk);
         #1;
      end
      if (i == 20)
      begin
         n_mismatch++;
         wrap_up();
      end
      else
      begin
         chk(32'(popCount), 32'(start) + 32'h0000_0002);
      end
   endtask : t_stall
   initial
   begin
      n_mismatch = 0;
      samples_checked = 0;
      rst = 1;
      stall = 0;
      pins = 4'hf;
      funcSel = 0;
      addr = 11'h000;
      byteMask = 4'h0;
      dqIn = 32'h0000_0000;
      repeat (10) @(posedge ref_clk);
      rst <= 0;
      #1;
      t_loads();
      t_writes();
      t_stall();
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
